// ---- dual_channel_torque_off_monitor.sv ----
// Two-channel torque off monitor: pulse gating, brake delay, discrepancy fault,
// restart sequence and test-due alarm.
// Assumes channel pins, enable and switch-on command are asynchronous pins.
//
// How it works
// - Brake output goes low 30 ms after torque off is triggered.
// - Both channels high means safe, motor may run.
// - Both channels low: restart sequencer is held in its off state and torque stays disabled.
// - Channels disagreeing is unsafe: discrepancy fault and coast stop.
// - Each channel forces pulse suppression on its own separate path.
// - Brake is commanded closed only when a brake is configured.
// - One-channel select then deselect within 2 s suppresses pulses silently.
// - Restart needs both deselected, enable, then a falling and rising switch-on edge.
// - Response to a torque off request comes within 5 ms.
// - A test-due timer runs with an 8760 hour period.
// - On expiry the test-due alarm is raised and held until tested.
// - Each torque off deactivation reloads the timer and keeps the alarm low.
// - The test-due alarm does not influence motor operation.
// - Selecting or deselecting torque off clears pending messages.
`timescale 1ns/10ps
`include "torque_off_consts.svh"
module dual_channel_torque_off_monitor
#(
  parameter int unsigned BRAKE_CYC = `BRAKE_DELAY_CYC,
  parameter int unsigned DISC_CYC = `DISC_WINDOW_CYC,
  parameter longint unsigned TEST_CYC = `TEST_PERIOD_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic safety_channel_a,
  input wire logic safety_channel_b,
  input wire logic drive_enable,
  input wire logic drive_switch_on_cmd,
  input wire logic brake_configured,
  input wire logic fault_ack,
  output logic pulse_enable_a,
  output logic pulse_enable_b,
  output logic brake_release,
  output logic discrepancy_fault,
  output logic coast_stop_response,
  output logic motor_run,
  output logic test_due_alarm,
  output logic torque_off_function
);
  logic ch_a;
  logic ch_b;
  logic en_s;
  logic son_s;
  logic ack_s;
  logic son_d_r;
  logic both_high;
  logic both_low;
  logic disagree;
  logic sto_active;
  logic sto_active_d_r;
  logic sto_rise;
  logic sto_fall;
  logic brake_done;
  logic disc_done;
  logic test_done;
  logic son_fall;
  logic son_rise;
  logic fault_set;
  logic msg_clear;
  logic disc_load;
  logic fault_nxt;
  logic alarm_nxt;
  logic run_nxt;
  logic brake_hold;
  logic brake_nxt;
  torque_off_pkg::restart_state_type state_r;
  torque_off_pkg::restart_state_type state_nxt;

  // Pin synchronisers with agreement filter
  input_filter u_fa (.clk(clk), .rstn(rstn), .pin(safety_channel_a), .rst_val(1'b0), .level(ch_a));
  input_filter u_fb (.clk(clk), .rstn(rstn), .pin(safety_channel_b), .rst_val(1'b0), .level(ch_b));
  input_filter u_fe (.clk(clk), .rstn(rstn), .pin(drive_enable), .rst_val(1'b0), .level(en_s));
  input_filter u_fs (.clk(clk), .rstn(rstn), .pin(drive_switch_on_cmd), .rst_val(1'b0),
    .level(son_s));
  input_filter u_fk (.clk(clk), .rstn(rstn), .pin(fault_ack), .rst_val(1'b0), .level(ack_s));

  // Channel state decode
  assign both_high = ch_a && ch_b;
  assign both_low = !ch_a && !ch_b;
  assign disagree = ch_a ^ ch_b;
  assign sto_active = !both_high; // Any low channel selects torque off
  assign sto_rise = sto_active && !sto_active_d_r;
  assign sto_fall = !sto_active && sto_active_d_r;
  assign son_fall = son_d_r && !son_s;
  assign son_rise = !son_d_r && son_s;
  assign msg_clear = sto_rise || sto_fall;

  // Brake delay timer, restarted at each torque off trigger
  cycle_timer #(.W(`CNT_W)) u_brake (.clk(clk), .rstn(rstn), .load(!sto_active),
    .run(sto_active), .load_val(BRAKE_CYC[`CNT_W-1:0]), .done(brake_done));

  // Discrepancy tolerance timer, held loaded while channels agree
  assign disc_load = !disagree;
  cycle_timer #(.W(`CNT_W)) u_disc (.clk(clk), .rstn(rstn), .load(disc_load),
    .run(disagree), .load_val(DISC_CYC[`CNT_W-1:0]), .done(disc_done));

  // Test-due timer, reloaded when torque off is deactivated
  cycle_timer #(.W(`TEST_W)) u_test (.clk(clk), .rstn(rstn), .load(sto_fall),
    .run(1'b1), .load_val(TEST_CYC[`TEST_W-1:0]), .done(test_done));

  // Fault: set wins over clear; clears by acknowledge or torque off select change
  assign fault_set = disagree && disc_done;
  assign fault_nxt = fault_set || (discrepancy_fault && !(ack_s || msg_clear));
  // Alarm latches on expiry, only a path test clears it
  assign alarm_nxt = (test_done && !sto_fall) || (test_due_alarm && !sto_fall);

  // Restart sequencer: deselect, enable, 1/0 then 0/1 switch-on edge
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      torque_off_pkg::st_off_type:
        if (both_high && en_s && !discrepancy_fault) state_nxt = torque_off_pkg::st_enabled_type;
      torque_off_pkg::st_enabled_type:
        if (son_fall) state_nxt = torque_off_pkg::st_low_seen_type;
      torque_off_pkg::st_low_seen_type:
        if (son_rise) state_nxt = torque_off_pkg::st_run_type;
      torque_off_pkg::st_run_type:
        state_nxt = state_r;
    endcase
    if (sto_active || !en_s || discrepancy_fault)
      state_nxt = torque_off_pkg::st_off_type;
  end
  // Run is independent of the test-due alarm
  assign run_nxt = (state_nxt == torque_off_pkg::st_run_type);
  // Brake stays open through the closing delay of a torque off, then closes
  assign brake_hold = brake_release && sto_active && !brake_done;
  assign brake_nxt = brake_configured ? (run_nxt || brake_hold) : !`BRAKE_CLOSED_LVL;

  // Edge history and sequencer state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sto_active_d_r <= 1'b1;
      son_d_r <= 1'b0;
      state_r <= torque_off_pkg::st_off_type;
    end
    else
    begin
      sto_active_d_r <= sto_active;
      son_d_r <= son_s;
      state_r <= state_nxt;
    end
  end

  // Registered outputs; each pulse path gated by its own channel and the run state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pulse_enable_a <= 1'b0;
      pulse_enable_b <= 1'b0;
      brake_release <= `BRAKE_CLOSED_LVL;
      discrepancy_fault <= 1'b0;
      coast_stop_response <= 1'b0;
      motor_run <= 1'b0;
      test_due_alarm <= 1'b0;
      torque_off_function <= 1'b1;
    end
    else
    begin
      pulse_enable_a <= ch_a && run_nxt;
      pulse_enable_b <= ch_b && run_nxt;
      brake_release <= brake_nxt;
      discrepancy_fault <= fault_nxt;
      coast_stop_response <= fault_nxt;
      motor_run <= run_nxt;
      test_due_alarm <= alarm_nxt;
      torque_off_function <= sto_active;
    end
  end

  // Checks
  sequence sto_trig_s;
    $rose(torque_off_function);
  endsequence
  sequence one_side_s;
    ch_a != ch_b;
  endsequence
  pulse_path_a: assert property (@(posedge clk) disable iff (!rstn)
    !ch_a |=> !pulse_enable_a) else $error("pulse path a not suppressed");
  pulse_path_b_a: assert property (@(posedge clk) disable iff (!rstn)
    !ch_b |=> !pulse_enable_b) else $error("pulse path b not suppressed");
  low_no_run_a: assert property (@(posedge clk) disable iff (!rstn)
    both_low |=> !motor_run) else $error("motor runs with both channels low");
  fault_coast_a: assert property (@(posedge clk) disable iff (!rstn)
    discrepancy_fault |-> coast_stop_response && !motor_run) else $error("fault without coast");
  no_early_fault_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(discrepancy_fault) |-> $past(disagree, 2)) else $error("fault without disagreement");
  brake_open_a: assert property (@(posedge clk) disable iff (!rstn)
    !brake_configured |=> brake_release) else $error("brake driven without configuration");
  brake_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    sto_trig_s ##0 brake_release ##1 torque_off_function |-> brake_release)
    else $error("brake closed at torque off trigger");
  brake_close_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(brake_release) && $past(sto_active) |-> $past(brake_done))
    else $error("brake closed before its delay");
  alarm_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    sto_fall |=> !test_due_alarm) else $error("alarm kept after path test");
  run_seq_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(motor_run) |-> $past(son_rise)) else $error("run without switch-on edge");
  sto_resp_a: assert property (@(posedge clk) disable iff (!rstn)
    one_side_s |-> ##[1:2] !motor_run) else $error("torque off response late");
endmodule

// ---- torque_off_consts.svh ----
// Timing constants and level encodings for the two-channel torque off monitor.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef TORQUE_OFF_CONSTS_SVH
`define TORQUE_OFF_CONSTS_SVH
`define CLK_FREQ_HZ 100000000
`define BRAKE_DELAY_MS 30
`define BRAKE_DELAY_CYC ((`BRAKE_DELAY_MS * (`CLK_FREQ_HZ / 1000)))
`define DISC_WINDOW_MS 2000
`define DISC_WINDOW_CYC ((`DISC_WINDOW_MS * (`CLK_FREQ_HZ / 1000)))
`define RESPONSE_MS 5
`define RESPONSE_CYC ((`RESPONSE_MS * (`CLK_FREQ_HZ / 1000)))
`define TEST_PERIOD_HOURS 8760
`define TEST_PERIOD_CYC (64'd8760 * 64'd3600 * 64'd100000000)
`define BRAKE_CLOSED_LVL 1'b0
`define CNT_W 28
`define TEST_W 52
`endif

// ---- torque_off_pkg.sv ----
// Types shared by the torque off monitor files.
// Assumes nothing beyond a SystemVerilog compiler.
package torque_off_pkg;
  typedef enum logic [1:0] {
    st_off_type = 2'b00,
    st_enabled_type = 2'b01,
    st_low_seen_type = 2'b11,
    st_run_type = 2'b10
  } restart_state_type;
endpackage

// ---- input_filter.sv ----
// Three-flop synchroniser for one pin; output changes once stages two and three agree.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
module input_filter
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  input wire logic rst_val,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic agree;
  // Agreement of the two settled stages
  assign agree = (s2_r == s3_r);
  // Shift chain and filtered level
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree)
      begin
        level <= s3_r;
      end
    end
  end
  // Unused strap port kept tied off by the parent
  logic unused_ok;
  assign unused_ok = rst_val;
endmodule

// ---- cycle_timer.sv ----
// Down counter: load sets it, it counts to zero and then raises done.
// Assumes load and run come from logic on clk.
`timescale 1ns/10ps
module cycle_timer
#(
  parameter int W = 28
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic run,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic zero;
  // Next count: load wins, else step down while running
  assign zero = (cnt_r == {W{1'b0}});
  assign cnt_nxt = load ? load_val : ((run && !zero) ? cnt_r - {{(W-1){1'b0}}, 1'b1} : cnt_r);
  // Counter and expiry flag
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= {W{1'b1}};
      done <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done <= !load && (cnt_nxt == {W{1'b0}});
    end
  end
endmodule

// ---- safety_device_model.sv ----
// Model of the two external safety switching devices that feed the channel pins.
// Assumes the bench sets its contact commands synchronously to clk.
`timescale 1ns/10ps
module safety_device_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic close_a,
  input wire logic close_b,
  output logic chan_a,
  output logic chan_b
);
  // Each contact follows its own command one cycle later; low selects torque off
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chan_a <= 1'b0;
      chan_b <= 1'b0;
    end
    else
    begin
      chan_a <= close_a;
      chan_b <= close_b;
    end
  end
endmodule

// ---- dual_channel_torque_off_monitor_tb.sv ----
// Self-checking bench for the two-channel torque off monitor.
// Assumes short timer parameters so the run stays brief.
`timescale 1ns/10ps
module dual_channel_torque_off_monitor_tb;
  localparam int BRAKE = 20;
  localparam int DISC = 50;
  logic clk, rstn, cmd_a, cmd_b, ch_a, ch_b, en, sw, brk_cfg, ack;
  logic pe_a, pe_b, brake, fault, coast, run, alarm, tof;
  int error_cnt = 0;
  int total_checks = 0;
  int i;
  logic [2:0] rows [5] = '{3'b110, 3'b101, 3'b001, 3'b011, 3'b110};

  safety_device_model safety_device_model_inst (.clk(clk), .rstn(rstn), .close_a(cmd_a),
    .close_b(cmd_b), .chan_a(ch_a), .chan_b(ch_b));
  dual_channel_torque_off_monitor #(.BRAKE_CYC(BRAKE), .DISC_CYC(DISC), .TEST_CYC(200))
    dual_channel_torque_off_monitor_inst (.clk(clk), .rstn(rstn), .safety_channel_a(ch_a),
    .safety_channel_b(ch_b), .drive_enable(en), .drive_switch_on_cmd(sw),
    .brake_configured(brk_cfg), .fault_ack(ack), .pulse_enable_a(pe_a), .pulse_enable_b(pe_b),
    .brake_release(brake), .discrepancy_fault(fault), .coast_stop_response(coast),
    .motor_run(run), .test_due_alarm(alarm), .torque_off_function(tof));

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one design output with its expected level
  task automatic chk(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: %s is %b, expected %b", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Sets both contact commands at a rising edge
  task automatic chans(input logic a, input logic b);
    @(posedge clk);
    cmd_a <= a;
    cmd_b <= b;
  endtask

  // Enable, then a falling and a rising switch-on edge
  task automatic restart();
    @(posedge clk);
    en <= 1'b1;
    tick(8);
    sw <= 1'b0;
    tick(8);
    sw <= 1'b1;
    tick(10);
  endtask

  task automatic conclude();
    $display("Checks made: %0d, mismatches: %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence: reset, table of channel levels, then hand-written cases
  initial
  begin
    rstn = 1'b0;
    cmd_a = 1'b0;
    cmd_b = 1'b0;
    en = 1'b0;
    sw = 1'b1;
    brk_cfg = 1'b1;
    ack = 1'b0;
    tick(6);
    rstn <= 1'b1;
    tick(2);
    chk(tof, 1'b1, "torque off after reset");
    chk(run, 1'b0, "run after reset");
    chk(brake, 1'b0, "brake after reset");
    // Each row holds the channels for 12 cycles, well inside the tolerance window
    for (i = 0; i < 5; i++)
    begin
      chans(rows[i][2], rows[i][1]);
      tick(12);
      chk(tof, rows[i][0], "torque off level");
      chk(fault, 1'b0, "early fault");
      if (!rows[i][2]) chk(pe_a, 1'b0, "path a pulses");
      if (!rows[i][1]) chk(pe_b, 1'b0, "path b pulses");
      if (rows[i][2:1] == 2'b00) chk(run, 1'b0, "run with both low");
    end
    // Switch-on edges without enable are ignored
    sw <= 1'b0;
    tick(8);
    sw <= 1'b1;
    tick(10);
    chk(run, 1'b0, "run without enable");
    // Short one-channel select is silent
    chans(1'b0, 1'b1);
    tick(20);
    chk(pe_a, 1'b0, "pulses during short select");
    chans(1'b1, 1'b1);
    tick(10);
    chk(fault, 1'b0, "fault after short select");
    // Lasting disagreement raises the fault and coast stop
    chans(1'b1, 1'b0);
    tick(DISC - 15);
    chk(fault, 1'b0, "fault inside window");
    tick(30);
    chk(fault, 1'b1, "discrepancy fault");
    chk(coast, 1'b1, "coast stop");
    // Fault survives a move to both low; the acknowledge then clears it
    chans(1'b0, 1'b0);
    tick(10);
    chk(fault, 1'b1, "fault held while both low");
    ack <= 1'b1;
    tick(2);
    ack <= 1'b0;
    tick(10);
    chk(fault, 1'b0, "fault acknowledged");
    // A fresh fault is withdrawn by deselecting torque off
    chans(1'b1, 1'b0);
    tick(DISC + 15);
    chk(fault, 1'b1, "second discrepancy fault");
    chans(1'b1, 1'b1);
    tick(10);
    chk(fault, 1'b0, "fault cleared");
    restart();
    chk(run, 1'b1, "run after restart");
    chk(pe_a & pe_b, 1'b1, "pulses after restart");
    chk(brake, 1'b1, "brake open while running");
    // Test-due alarm after the shortened period, while running
    for (i = 0; i < 400 && alarm !== 1'b1; i++)
      tick(1);
    chk(alarm, 1'b1, "test due alarm");
    tick(5);
    chk(alarm, 1'b1, "alarm held");
    chk(run, 1'b1, "run under alarm");
    // Torque off from run: fast suppression, brake closed past the delay
    chans(1'b0, 1'b0);
    tick(10);
    chk(run, 1'b0, "run after torque off");
    chk(pe_a | pe_b, 1'b0, "pulses after torque off");
    chk(brake, 1'b1, "brake held open during delay");
    tick(BRAKE + 10);
    chk(brake, 1'b0, "brake closed after delay");
    chans(1'b1, 1'b1);
    tick(10);
    chk(alarm, 1'b0, "alarm after path test");
    // Without a fitted brake the brake output is never closed
    brk_cfg <= 1'b0;
    en <= 1'b0;
    restart();
    chk(run, 1'b1, "run second restart");
    chk(brake, 1'b1, "brake left open without fitted brake");
    chans(1'b0, 1'b0);
    tick(BRAKE + 16);
    chk(run, 1'b0, "run after unbraked torque off");
    chk(brake, 1'b1, "brake untouched without configuration");
    conclude();
  end

  // Cuts a hang short
  initial
  begin
    #900000;
    error_cnt++;
    $display("ERROR at %0t: run limit reached", $time);
    conclude();
  end
endmodule
